// ===== t1_rx_path_mode_config.sv
// fifo and top level of the t1 receive path mode configuration and backplane output stage
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module t1rx_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wrPtr_q;
  logic [PW:0]      rdPtr_q;
  logic             push;
  logic             pop;

  assign inReady  = (wrPtr_q - rdPtr_q) != (PW+1)'(DEPTH);
  assign outValid = wrPtr_q != rdPtr_q;
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign outData  = mem[rdPtr_q[PW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q[PW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + (PW+1)'(1);
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + (PW+1)'(1);
      end
    end
  end
endmodule : t1rx_fifo

////////////////////////////////////////////////////////////////////////////////

// What this block does
// [R1] mode 80h selects clock slave referenced to backplane clock
// [R2] mode C0h selects slave external signaling at 1.544 Mbit/s
// [R3] mode D0h selects slave external signaling at 2.048 Mbit/s
// [R4] mode 40h selects full-rate clock master sourcing its own backplane clock
// [R5] options 13h in slave: drive data on clock rise, sample frame pulse falling
// [R6] external signaling with options 13h enables data and signaling, updated on rise
// [R7] master with options 10h enables data, data and frame pulse change on own rise
// [R8] framer config 30h gives extended superframe with crc-6 during mimic pattern
// [R9] framer config zero gives superframe
// [R10] alarm config 10h gives extended superframe alarm evaluation
// [R11] alarm config zero gives superframe alarm evaluation
// [R12] signaling buffer config 04h gives extended superframe extraction
// [R13] signaling buffer config zero gives superframe extraction
// [R14] five receive modes and four transmit modes are selectable; only the five receive modes are decoded here, no transmit mode register exists
// [R15] each framer's registers repeat every 80h index for eight framers
// [R16] reset gives t1, slave external signaling, superframe format
// [R17] software keeps framer, alarm and signaling formats consistent
module t1_rx_path_mode_config (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // avalon-mm slave, byte address
  input  wire logic [t1rx_pkg::ADDR_W-1:0]  avsAddress,
  input  wire logic                         avsRead,
  input  wire logic                         avsWrite,
  input  wire logic [31:0]                  avsWritedata,
  output logic      [31:0]                  avsReaddata,
  output logic                              avsWaitrequest,
  // payload from the receive frame processor
  input  wire t1rx_pkg::t1rx_word_t         payloadIn,
  input  wire logic                         payloadValid,
  output logic                              payloadReady,
  // backplane pins
  input  wire logic                         rxBackplaneCommonClock,
  input  wire logic                         rxBackplaneCommonFramePulse,
  output t1rx_pkg::t1rx_backplane_t         rxBackplane,
  output logic                              rxFrameAligned,
  // per-framer decoded configuration, then backplane rate and receive mode of framer 0
  output logic [t1rx_pkg::FRAMER_COUNT-1:0] framerEsf,
  output logic [t1rx_pkg::FRAMER_COUNT-1:0] framerCrcOnMimic,
  output logic [t1rx_pkg::FRAMER_COUNT-1:0] alarmEsf,
  output logic [t1rx_pkg::FRAMER_COUNT-1:0] sigbufEsf,
  output logic                              backplaneRate2048,
  output t1rx_pkg::t1rx_rx_mode_t           rxMode
);
  localparam int NF = t1rx_pkg::FRAMER_COUNT;

  logic [7:0] modeQ [NF];
  logic [7:0] optQ  [NF];
  logic [7:0] frmpQ [NF];
  logic [7:0] almdQ [NF];
  logic [7:0] sigQ  [NF];

  logic       ack_q;
  logic [9:0] regIdx;
  logic [2:0] fSel;
  logic [6:0] rOff;
  logic       wrEn;
  logic [7:0] rdByte;
  logic       rdHit;
  logic [31:0] readdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then the access completes

  assign regIdx         = avsAddress[t1rx_pkg::ADDR_W-1:2];
  assign fSel           = regIdx[9:7];
  assign rOff           = regIdx[6:0];
  assign avsWaitrequest = (avsRead | avsWrite) & ~ack_q;
  assign wrEn           = avsWrite & ack_q;
  assign avsReaddata    = readdata_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avsRead | avsWrite) & ~ack_q;
    end
  end

  always_comb begin
    rdHit  = 1'b1;
    rdByte = 8'h00;
    unique case (rOff)
      t1rx_pkg::IDX_RX_INTERFACE_MODE:    rdByte = modeQ[fSel];
      t1rx_pkg::IDX_RX_INTERFACE_OPTIONS: rdByte = optQ[fSel];
      t1rx_pkg::IDX_RX_FRAMER_CONFIG:     rdByte = frmpQ[fSel];
      t1rx_pkg::IDX_RX_ALARM_CONFIG:      rdByte = almdQ[fSel];
      t1rx_pkg::IDX_RX_SIGBUF_CONFIG:     rdByte = sigQ[fSel];
      default:                            rdHit  = 1'b0;
    endcase
  end

  // data captured in the wait cycle so it is stable at the completing edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readdata_q <= 32'h0;
    end else if (avsRead & ~ack_q) begin
      readdata_q <= rdHit ? {24'h0, rdByte} : 32'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-framer register copies and format decode

  for (genvar f = 0; f < NF; f++) begin : gFramer
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        modeQ[f] <= t1rx_pkg::RST_MODE; // R16
        optQ[f]  <= t1rx_pkg::RST_OPTIONS;
        frmpQ[f] <= t1rx_pkg::RST_FRAME_PROCESSOR;
        almdQ[f] <= t1rx_pkg::RST_ALARM_DETECTOR;
        sigQ[f]  <= t1rx_pkg::RST_SIGBUF;
      end else if (wrEn && fSel == 3'(f)) begin // R15
        unique case (rOff)
          t1rx_pkg::IDX_RX_INTERFACE_MODE:    modeQ[f] <= avsWritedata[7:0];
          t1rx_pkg::IDX_RX_INTERFACE_OPTIONS: optQ[f]  <= avsWritedata[7:0];
          t1rx_pkg::IDX_RX_FRAMER_CONFIG:     frmpQ[f] <= avsWritedata[7:0];
          t1rx_pkg::IDX_RX_ALARM_CONFIG:      almdQ[f] <= avsWritedata[7:0];
          t1rx_pkg::IDX_RX_SIGBUF_CONFIG:     sigQ[f]  <= avsWritedata[7:0];
          default: ;
        endcase
      end
    end
    // superframe whenever the esf field is clear
    assign framerEsf[f]        = frmpQ[f][t1rx_pkg::FRAME_PROCESSOR_ESF_BIT]; // R8 R9
    assign framerCrcOnMimic[f] = frmpQ[f][t1rx_pkg::FRAME_PROCESSOR_CRC_MIMIC_BIT]; // R8
    assign alarmEsf[f]         = almdQ[f][t1rx_pkg::ALARM_DETECTOR_ESF_BIT]; // R10 R11
    assign sigbufEsf[f]        = sigQ[f][t1rx_pkg::SIGBUF_ESF_BIT]; // R12 R13
  end

  //////////////////////////////////////////////////////////////////////////////
  // receive mode of framer 0, which owns the backplane pins here

  always_comb begin
    unique case (modeQ[0])
      t1rx_pkg::MODE_SLAVE_CLKREF:  rxMode = t1rx_pkg::T1RX_RX_SLAVE_CLKREF; // R1
      t1rx_pkg::MODE_SLAVE_EXT1544: rxMode = t1rx_pkg::T1RX_RX_SLAVE_EXT1544; // R2
      t1rx_pkg::MODE_SLAVE_EXT2048: rxMode = t1rx_pkg::T1RX_RX_SLAVE_EXT2048; // R3
      t1rx_pkg::MODE_MASTER_FULL:   rxMode = t1rx_pkg::T1RX_RX_MASTER_FULL; // R4
      t1rx_pkg::MODE_MASTER_FRAC:   rxMode = t1rx_pkg::T1RX_RX_MASTER_FRAC; // R14
      default:                      rxMode = t1rx_pkg::T1RX_RX_UNSUPPORTED;
    endcase
  end

  logic isSlave;
  logic isExt;
  logic isMasterFull;
  assign isExt        = rxMode == t1rx_pkg::T1RX_RX_SLAVE_EXT1544 || rxMode == t1rx_pkg::T1RX_RX_SLAVE_EXT2048;
  assign isSlave      = isExt || rxMode == t1rx_pkg::T1RX_RX_SLAVE_CLKREF;
  assign isMasterFull = rxMode == t1rx_pkg::T1RX_RX_MASTER_FULL;
  // the slave follows the common clock, so the rate only informs downstream timing
  assign backplaneRate2048 = rxMode == t1rx_pkg::T1RX_RX_SLAVE_EXT2048; // R3

  //////////////////////////////////////////////////////////////////////////////
  // payload buffer

  t1rx_pkg::t1rx_word_t fifoOut;
  logic                 fifoValid;
  logic                 fifoPop;

  t1rx_fifo #(
    .WIDTH ($bits(t1rx_pkg::t1rx_word_t)),
    .DEPTH (t1rx_pkg::FIFO_DEPTH)
  ) uFifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inData   (payloadIn),
    .inValid  (payloadValid),
    .inReady  (payloadReady),
    .outData  (fifoOut),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and common clock edge detection

  logic ckSync1_q;
  logic ckSync2_q;
  logic ckPrev_q;
  logic fpSync1_q;
  logic fpSync2_q;
  logic ckRise;
  logic ckFall;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ckSync1_q <= 1'b0;
      ckSync2_q <= 1'b0;
      ckPrev_q  <= 1'b0;
      fpSync1_q <= 1'b0;
      fpSync2_q <= 1'b0;
    end else begin
      ckSync1_q <= rxBackplaneCommonClock;
      ckSync2_q <= ckSync1_q;
      ckPrev_q  <= ckSync2_q;
      fpSync1_q <= rxBackplaneCommonFramePulse;
      fpSync2_q <= fpSync1_q;
    end
  end

  assign ckRise = ckSync2_q & ~ckPrev_q;
  assign ckFall = ~ckSync2_q & ckPrev_q;

  //////////////////////////////////////////////////////////////////////////////
  // master clock divider and frame counter

  logic [6:0] divCnt_q;
  logic       mClk_q;
  logic       mRise;
  logic [7:0] bitCnt_q;

  assign mRise = isMasterFull && !mClk_q && divCnt_q == 7'(t1rx_pkg::MASTER_HALF_CYC - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_q <= 7'h00;
      mClk_q   <= 1'b0;
    end else if (!isMasterFull) begin
      divCnt_q <= 7'h00;
      mClk_q   <= 1'b0;
    end else if (divCnt_q == 7'(t1rx_pkg::MASTER_HALF_CYC - 1)) begin
      divCnt_q <= 7'h00;
      mClk_q   <= ~mClk_q; // R4
    end else begin
      divCnt_q <= divCnt_q + 7'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt_q <= 8'h00;
    end else if (!isMasterFull) begin
      bitCnt_q <= 8'h00;
    end else if (mRise) begin
      bitCnt_q <= (bitCnt_q == 8'(t1rx_pkg::FRAME_BITS - 1)) ? 8'h00 : bitCnt_q + 8'h01;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // backplane output stage

  logic slaveDriveEdge;
  logic slaveSampleEdge;
  logic driveEdge;
  logic dataEn;
  logic data_q;
  logic sig_q;
  logic fpOut_q;
  logic aligned_q;

  assign slaveDriveEdge  = isSlave && (optQ[0][t1rx_pkg::OPT_DRIVE_RISE_BIT] ? ckRise : ckFall); // R5
  assign slaveSampleEdge = isSlave && (optQ[0][t1rx_pkg::OPT_FP_FALL_BIT] ? ckFall : ckRise); // R5
  assign driveEdge       = slaveDriveEdge | mRise; // R7
  assign dataEn          = optQ[0][t1rx_pkg::OPT_DATA_EN_BIT] & (isSlave | isMasterFull);
  // an empty buffer stalls nothing on the line side; the pin idles high instead
  assign fifoPop         = driveEdge & dataEn & fifoValid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= 1'b1;
      sig_q  <= 1'b1;
    end else if (driveEdge && dataEn) begin
      data_q <= fifoValid ? fifoOut.data : 1'b1; // R5 R6 R7
      sig_q  <= fifoValid ? fifoOut.signaling : 1'b1; // R6
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fpOut_q <= 1'b0;
    end else if (mRise) begin
      fpOut_q <= bitCnt_q == 8'h00; // R7
    end else if (!isMasterFull) begin
      fpOut_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aligned_q <= 1'b0;
    end else if (slaveSampleEdge) begin
      aligned_q <= fpSync2_q; // R5
    end else if (!isSlave) begin
      aligned_q <= 1'b0;
    end
  end

  assign rxFrameAligned           = aligned_q;
  assign rxBackplane.data         = data_q;
  assign rxBackplane.dataOe       = dataEn; // R6 R7
  assign rxBackplane.signaling    = sig_q;
  assign rxBackplane.signalingOe  = dataEn & isExt; // R6
  assign rxBackplane.framePulse   = fpOut_q;
  assign rxBackplane.framePulseOe = dataEn & isMasterFull; // R7
  assign rxBackplane.clockOut     = mClk_q;
  assign rxBackplane.clockOutOe   = isMasterFull; // R4

  //////////////////////////////////////////////////////////////////////////////
  // checks

  AST_BUS_ONE_WAIT: assert property (@(posedge clk) disable iff (!rst_n) // bus timing is this design's own
    $rose(avsRead | avsWrite) |-> avsWaitrequest ##1 !avsWaitrequest)
    else $error("bus access did not complete after one wait cycle");

  AST_FRAMER_STRIDE: assert property (@(posedge clk) disable iff (!rst_n) // R15
    wrEn && rOff == t1rx_pkg::IDX_RX_FRAMER_CONFIG && fSel == 3'h1
    |=> frmpQ[1] == $past(avsWritedata[7:0]) && $stable(frmpQ[0]))
    else $error("framer config write reached the wrong framer copy");

  AST_MODE_DECODE: assert property (@(posedge clk) disable iff (!rst_n) // R1
    modeQ[0] == t1rx_pkg::MODE_SLAVE_CLKREF |-> isSlave && !isExt && !rxBackplane.clockOutOe)
    else $error("clock reference slave mode decoded wrongly");

  AST_EXT_RATE: assert property (@(posedge clk) disable iff (!rst_n) // R2
    modeQ[0] == t1rx_pkg::MODE_SLAVE_EXT1544 |-> isExt && !backplaneRate2048)
    else $error("1.544 external signaling mode decoded wrongly");

  AST_MASTER_CLOCK: assert property (@(posedge clk) disable iff (!rst_n) // R4
    isMasterFull && $rose(mClk_q) |-> ##[63:64] $fell(mClk_q))
    else $error("master backplane clock half period wrong");

  AST_SLAVE_DRIVE: assert property (@(posedge clk) disable iff (!rst_n) // R5
    isSlave && optQ[0] == t1rx_pkg::OPT_SLAVE_NORMAL && ckRise && fifoValid
    |=> data_q == $past(fifoOut.data))
    else $error("slave data not driven on common clock rise");

  AST_EXT_ENABLES: assert property (@(posedge clk) disable iff (!rst_n) // R6
    isExt && optQ[0] == t1rx_pkg::OPT_SLAVE_NORMAL |-> rxBackplane.dataOe && rxBackplane.signalingOe)
    else $error("external signaling outputs not enabled");

  AST_MASTER_FP: assert property (@(posedge clk) disable iff (!rst_n) // R7
    mRise && bitCnt_q == 8'h00 && optQ[0] == t1rx_pkg::OPT_MASTER_NORMAL
    |=> rxBackplane.framePulse && rxBackplane.framePulseOe && rxBackplane.dataOe)
    else $error("master frame pulse missing at frame start");

  AST_ESF_DECODE: assert property (@(posedge clk) disable iff (!rst_n) // R8
    frmpQ[0] == t1rx_pkg::FRAME_PROCESSOR_ESF_CRC && almdQ[0] == t1rx_pkg::ALARM_DETECTOR_ESF && sigQ[0] == t1rx_pkg::SIGBUF_ESF
    |-> framerEsf[0] && framerCrcOnMimic[0] && alarmEsf[0] && sigbufEsf[0])
    else $error("extended superframe decode wrong");

  AST_SF_DECODE: assert property (@(posedge clk) disable iff (!rst_n) // R9
    frmpQ[0] == t1rx_pkg::FORMAT_SF && almdQ[0] == t1rx_pkg::FORMAT_SF && sigQ[0] == t1rx_pkg::FORMAT_SF
    |-> !framerEsf[0] && !alarmEsf[0] && !sigbufEsf[0])
    else $error("superframe decode wrong");

endmodule : t1_rx_path_mode_config

`default_nettype wire

// ===== t1rx_pkg.sv
// shared constants, register map and types for the t1 receive path mode configuration
package t1rx_pkg;

  // register indices within one framer block; byte address is four times the index
  localparam logic [6:0] IDX_RX_INTERFACE_MODE    = 7'h01;
  localparam logic [6:0] IDX_RX_INTERFACE_OPTIONS = 7'h03;
  localparam logic [6:0] IDX_RX_FRAMER_CONFIG     = 7'h20;
  localparam logic [6:0] IDX_RX_ALARM_CONFIG      = 7'h2C;
  localparam logic [6:0] IDX_RX_SIGBUF_CONFIG     = 7'h40;
  localparam int         FRAMER_STRIDE_IDX        = 128;
  localparam int         FRAMER_COUNT             = 8;
  localparam int         ADDR_W                   = 12;

  // interface mode encodings
  localparam logic [7:0] MODE_SLAVE_CLKREF  = 8'h80;
  localparam logic [7:0] MODE_SLAVE_EXT1544 = 8'hC0;
  localparam logic [7:0] MODE_SLAVE_EXT2048 = 8'hD0;
  localparam logic [7:0] MODE_MASTER_FULL   = 8'h40;
  localparam logic [7:0] MODE_MASTER_FRAC   = 8'h00;

  // option settings and field positions
  localparam logic [7:0] OPT_SLAVE_NORMAL  = 8'h13;
  localparam logic [7:0] OPT_MASTER_NORMAL = 8'h10;
  localparam int         OPT_DATA_EN_BIT   = 4;
  localparam int         OPT_DRIVE_RISE_BIT = 1;
  localparam int         OPT_FP_FALL_BIT   = 0;

  localparam logic [7:0] FRAME_PROCESSOR_ESF_CRC     = 8'h30;
  localparam int         FRAME_PROCESSOR_ESF_BIT     = 4;
  localparam int         FRAME_PROCESSOR_CRC_MIMIC_BIT = 5;
  localparam logic [7:0] ALARM_DETECTOR_ESF         = 8'h10;
  localparam int         ALARM_DETECTOR_ESF_BIT     = 4;
  localparam logic [7:0] SIGBUF_ESF       = 8'h04;
  localparam int         SIGBUF_ESF_BIT   = 2;
  localparam logic [7:0] FORMAT_SF        = 8'h00;

  // reset values: slave external signaling, superframe, backplane outputs off
  localparam logic [7:0] RST_MODE    = 8'hC0;
  localparam logic [7:0] RST_OPTIONS = 8'h00;
  localparam logic [7:0] RST_FRAME_PROCESSOR    = 8'h00;
  localparam logic [7:0] RST_ALARM_DETECTOR    = 8'h00;
  localparam logic [7:0] RST_SIGBUF  = 8'h00;

  // timing: master backplane clock derived from the core clock
  localparam int         CLK_FREQ_KHZ   = 200000;
  localparam int         T1_RATE_KBPS   = 1544;
  localparam int         MASTER_HALF_CYC = CLK_FREQ_KHZ / (2 * T1_RATE_KBPS);
  localparam int         FRAME_BITS     = 193;
  localparam int         FIFO_DEPTH     = 8;

  typedef enum {
    T1RX_RX_SLAVE_CLKREF,
    T1RX_RX_SLAVE_EXT1544,
    T1RX_RX_SLAVE_EXT2048,
    T1RX_RX_MASTER_FULL,
    T1RX_RX_MASTER_FRAC,
    T1RX_RX_UNSUPPORTED
  } t1rx_rx_mode_t;

  typedef enum {
    T1RX_TX_SLAVE_CLKREF,
    T1RX_TX_SLAVE_EXT,
    T1RX_TX_MASTER,
    T1RX_TX_MULTIPLEXED
  } t1rx_tx_mode_t;

  typedef struct packed {
    logic data;
    logic signaling;
  } t1rx_word_t;

  typedef struct packed {
    logic data;
    logic dataOe;
    logic signaling;
    logic signalingOe;
    logic framePulse;
    logic framePulseOe;
    logic clockOut;
    logic clockOutOe;
  } t1rx_backplane_t;

endpackage : t1rx_pkg

// ===== t1rx_tdm_model.sv
// behavioural model of the system tdm backplane that clocks the receive side
`timescale 1ns/1ps
`default_nettype none

module t1rx_tdm_model #(
  parameter int HALF_NS    = 32,
  parameter int FRAME_BITS = 193
) (
  input  wire logic run,
  output logic      commonClock,
  output logic      commonFramePulse
);
  int bitPos = 0;

  initial begin
    commonClock = 1'b0;
    commonFramePulse = 1'b0;
  end

  // clock stands still low while run is low so no stray edge reaches the block
  always begin
    #HALF_NS;
    commonClock = run ? ~commonClock : 1'b0;
  end

  // one-bit pulse on each framing bit, changed on the rise; pulled low while idle
  always @(posedge commonClock or negedge run) begin
    if (!run) begin
      commonFramePulse <= 1'b0;
      bitPos <= 0;
    end else begin
      commonFramePulse <= (bitPos == 0);
      bitPos <= (bitPos == FRAME_BITS - 1) ? 0 : bitPos + 1;
    end
  end
endmodule : t1rx_tdm_model
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the t1 receive path mode configuration
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic                      clk = 1'b0;
  logic                      rst_n = 1'b0;
  logic [11:0]               avsAddress = 12'h000;
  logic                      avsRead = 1'b0;
  logic                      avsWrite = 1'b0;
  logic [31:0]               avsWritedata = 32'h0;
  logic [31:0]               avsReaddata;
  logic                      avsWaitrequest;
  t1rx_pkg::t1rx_word_t      payloadIn = 2'h0;
  logic                      payloadValid = 1'b0;
  logic                      payloadReady;
  logic                      linkRun = 1'b0;
  logic                      commonClock;
  logic                      commonFramePulse;
  t1rx_pkg::t1rx_backplane_t rxBackplane;
  logic                      rxFrameAligned;
  logic [7:0]                framerEsf;
  logic [7:0]                framerCrcOnMimic;
  logic [7:0]                alarmEsf;
  logic [7:0]                sigbufEsf;
  logic                      backplaneRate2048;
  t1rx_pkg::t1rx_rx_mode_t   rxMode;
  int                        fail_count = 0;
  int                        check_count = 0;
  logic [31:0]               seed = 32'hF543E1AC;
  t1rx_pkg::t1rx_word_t      sent[$];
  logic [7:0]                modeTab[6] = '{8'h80, 8'hC0, 8'hD0, 8'h40, 8'h00, 8'h55};

  always #2.5 clk = ~clk;

  t1_rx_path_mode_config uut (.clk(clk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .payloadIn(payloadIn), .payloadValid(payloadValid),
    .payloadReady(payloadReady), .rxBackplaneCommonClock(commonClock),
    .rxBackplaneCommonFramePulse(commonFramePulse), .rxBackplane(rxBackplane),
    .rxFrameAligned(rxFrameAligned), .framerEsf(framerEsf), .framerCrcOnMimic(framerCrcOnMimic),
    .alarmEsf(alarmEsf), .sigbufEsf(sigbufEsf), .backplaneRate2048(backplaneRate2048), .rxMode(rxMode));

  t1rx_tdm_model partner (.run(linkRun), .commonClock(commonClock), .commonFramePulse(commonFramePulse));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [31:0] expMode(input logic [7:0] m);
    case (m)
      8'h80:   return 32'(t1rx_pkg::T1RX_RX_SLAVE_CLKREF);
      8'hC0:   return 32'(t1rx_pkg::T1RX_RX_SLAVE_EXT1544);
      8'hD0:   return 32'(t1rx_pkg::T1RX_RX_SLAVE_EXT2048);
      8'h40:   return 32'(t1rx_pkg::T1RX_RX_MASTER_FULL);
      8'h00:   return 32'(t1rx_pkg::T1RX_RX_MASTER_FRAC);
      default: return 32'(t1rx_pkg::T1RX_RX_UNSUPPORTED);
    endcase
  endfunction : expMode

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chkVal

  task automatic chkBit(input logic got, input logic exp);
    chkVal({31'h0, got}, {31'h0, exp});
  endtask : chkBit

  // caller stands just after a rising edge; request held until waitrequest is low
  task automatic bus(input logic wr, input int f, input logic [6:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    avsAddress <= {f[2:0], idx, 2'b00};
    avsWrite <= wr;
    avsRead <= ~wr;
    avsWritedata <= {24'h0, wd};
    // waitrequest and read data are taken at the rising edge itself, before the slave updates
    forever begin
      @(posedge clk);
      if (avsWaitrequest === 1'b0) break;
      n++;
      if (n > 100) begin
        fail_count++;
        summarize();
      end
    end
    rd = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    // one idle edge so the next call never re-raises a strobe in this time step
    @(posedge clk);
  endtask : bus

  task automatic wrReg(input int f, input logic [6:0] idx, input logic [7:0] v);
    logic [31:0] d;
    bus(1'b1, f, idx, v, d);
  endtask : wrReg

  task automatic rdReg(input int f, input logic [6:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    bus(1'b0, f, idx, 8'h00, d);
    chkVal(d, {24'h0, exp});
  endtask : rdReg

  task automatic waitRise(output int n);
    logic prev;
    n = 0;
    @(negedge clk);
    prev = rxBackplane.clockOut;
    forever begin
      @(negedge clk);
      n++;
      if (prev === 1'b0 && rxBackplane.clockOut === 1'b1) break;
      prev = rxBackplane.clockOut;
      if (n > 400) begin
        fail_count++;
        summarize();
      end
    end
  endtask : waitRise

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int f;
    int n;
    logic esf;
    logic [7:0] v;
    logic [31:0] r;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rdReg(i, t1rx_pkg::IDX_RX_INTERFACE_MODE, 8'hC0);
      rdReg(i, t1rx_pkg::IDX_RX_FRAMER_CONFIG, 8'h00);
    end
    chkVal(32'(rxMode), expMode(8'hC0));
    chkBit(rxBackplane.dataOe, 1'b0);
    wrReg(0, 7'h02, 8'hA5);
    rdReg(0, 7'h02, 8'h00);
    // random framer and values; formats kept consistent across the three blocks
    for (int i = 0; i < 40; i++) begin
      f = int'(rnd() % 8);
      r = rnd();
      v = r[7:0];
      esf = v[0];
      wrReg(f, t1rx_pkg::IDX_RX_INTERFACE_OPTIONS, v);
      wrReg(f, t1rx_pkg::IDX_RX_FRAMER_CONFIG, esf ? 8'h30 : 8'h00);
      wrReg(f, t1rx_pkg::IDX_RX_ALARM_CONFIG, esf ? 8'h10 : 8'h00);
      wrReg(f, t1rx_pkg::IDX_RX_SIGBUF_CONFIG, esf ? 8'h04 : 8'h00);
      rdReg(f, t1rx_pkg::IDX_RX_INTERFACE_OPTIONS, v);
      rdReg(f, t1rx_pkg::IDX_RX_ALARM_CONFIG, esf ? 8'h10 : 8'h00);
      chkBit(framerEsf[f], esf);
      chkBit(framerCrcOnMimic[f], esf);
      chkBit(alarmEsf[f], esf);
      chkBit(sigbufEsf[f], esf);
    end
    for (int i = 0; i < 6; i++) begin
      wrReg(0, t1rx_pkg::IDX_RX_INTERFACE_MODE, modeTab[i]);
      wrReg(0, t1rx_pkg::IDX_RX_INTERFACE_OPTIONS, modeTab[i] == 8'h40 ? 8'h10 : 8'h13);
      chkVal(32'(rxMode), expMode(modeTab[i]));
      chkBit(backplaneRate2048, modeTab[i] == 8'hD0);
      chkBit(rxBackplane.dataOe, i < 4);
      chkBit(rxBackplane.signalingOe, i == 1 || i == 2);
      chkBit(rxBackplane.clockOutOe, i == 3);
    end
    // fill the buffer while the link clock stands still, then drain it
    wrReg(0, t1rx_pkg::IDX_RX_INTERFACE_MODE, 8'hC0);
    r = rnd();
    payloadIn <= r[1:0];
    payloadValid <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if (payloadReady !== 1'b1) break;
      sent.push_back(payloadIn);
      @(posedge clk);
      r = rnd();
      payloadIn <= r[1:0];
    end
    @(posedge clk);
    payloadValid <= 1'b0;
    chkVal(sent.size(), 8);
    linkRun <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      @(negedge commonClock);
      chkBit(rxBackplane.data, i < 8 ? sent[i].data : 1'b1);
      chkBit(rxBackplane.signaling, i < 8 ? sent[i].signaling : 1'b1);
      chkBit(rxFrameAligned, i == 1);
    end
    @(posedge clk);
    linkRun <= 1'b0;
    // master: the held word leaves on the first rise of the own clock
    wrReg(0, t1rx_pkg::IDX_RX_INTERFACE_OPTIONS, 8'h00);
    wrReg(0, t1rx_pkg::IDX_RX_INTERFACE_MODE, 8'h40);
    payloadIn <= 2'h1;
    payloadValid <= 1'b1;
    @(posedge clk);
    payloadValid <= 1'b0;
    @(posedge clk);
    wrReg(0, t1rx_pkg::IDX_RX_INTERFACE_OPTIONS, 8'h10);
    waitRise(n);
    chkBit(rxBackplane.data, 1'b0);
    chkBit(rxBackplane.framePulse, 1'b1);
    chkBit(rxBackplane.framePulseOe, 1'b1);
    waitRise(n);
    chkVal(n + 1, 2 * t1rx_pkg::MASTER_HALF_CYC);
    chkBit(rxBackplane.data, 1'b1);
    chkBit(rxBackplane.framePulse, 1'b0);
    summarize();
  end

  initial begin
    #200000;
    fail_count++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
